// ===== src/tlviu_top.sv
`timescale 1ns/10ps
module tlviu_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Request pins
  input wire logic ext_request_pin_0,
  input wire logic ext_request_pin_1,
  // Timer and serial events
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic receive_done,
  input wire logic transmit_done,
  // Core sequencer
  input wire logic core_last_cycle,
  input wire logic core_return_from_isr,
  input wire logic core_return_sub,
  input wire logic core_pc_stack_ack,
  output logic sample_phase,
  output logic forced_vector_call,
  output logic [15:0] vector_addr,
  output logic push_pc,
  output logic save_psw,
  output logic pop_pc,
  output logic [1:0] active_levels
);
  import tlviu_pkg::*;

  typedef enum logic [2:0] {
    TLVIU_IDLE = 3'b001,
    TLVIU_CALL1 = 3'b010,
    TLVIU_CALL2 = 3'b100
  } tlviu_state_e;

  tlviu_state_e state;
  tlviu_state_e next_state;
  logic [3:0] phase_cnt;
  logic poll_en;
  logic [7:0] timer_control_reg;
  logic [7:0] serial_control_reg;
  logic [7:0] interrupt_enable_reg;
  logic [7:0] priority_select_reg;
  logic pin0_lvl;
  logic pin1_lvl;
  logic pin0_prev;
  logic pin1_prev;
  logic [4:0] latched;
  logic hold_one;
  logic ie_wr_seen;
  logic [2:0] call_src;
  logic call_high;
  logic accept;
  logic [4:0] clr_mask;
  tlviu_req_if req ();

  function automatic logic [15:0] vec_of(input logic [2:0] s);
    unique case (s)
      3'(SRC_EXT0): vec_of = VEC_EXT0;
      3'(SRC_TMR0): vec_of = VEC_TMR0;
      3'(SRC_EXT1): vec_of = VEC_EXT1;
      3'(SRC_TMR1): vec_of = VEC_TMR1;
      default: vec_of = VEC_SER;
    endcase
  endfunction

  tlviu_pin_sync u_sync0 (
    .clk(clk),
    .rst_n(rst_n),
    .pin(ext_request_pin_0),
    .level(pin0_lvl)
  );
  tlviu_pin_sync u_sync1 (
    .clk(clk),
    .rst_n(rst_n),
    .pin(ext_request_pin_1),
    .level(pin1_lvl)
  );
  tlviu_poll_arb u_arb (
    .req(req.arb)
  );

  // Machine cycle divider; one enable pulse per cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_cnt <= 4'h0;
      sample_phase <= 1'b0;
    end else begin
      phase_cnt <= (phase_cnt == SAMPLE_PHASE_CNT) ? 4'h0 : phase_cnt + 4'h1;
      sample_phase <= (phase_cnt == SAMPLE_PHASE_CNT - 4'h1);
    end
  end
  assign poll_en = sample_phase;

  always_comb begin
    clr_mask = 5'h00;
    if (accept) begin
      unique case (req.src)
        3'(SRC_EXT0): clr_mask[SRC_EXT0] = timer_control_reg[TC_EXT0_EDGE];
        3'(SRC_TMR0): clr_mask[SRC_TMR0] = 1'b1;
        3'(SRC_EXT1): clr_mask[SRC_EXT1] = timer_control_reg[TC_EXT1_EDGE];
        3'(SRC_TMR1): clr_mask[SRC_TMR1] = 1'b1;
        default: clr_mask = 5'h00;
      endcase
    end
  end

  // Timer control: hardware sets win over software writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_reg <= RESET_VAL;
      pin0_prev <= 1'b1;
      pin1_prev <= 1'b1;
    end else begin
      if (reg_wr && reg_addr == ADDR_TIMER_CTRL) begin
        timer_control_reg <= reg_wdata;
      end
      if (clr_mask[SRC_EXT0]) begin
        timer_control_reg[TC_EXT0_FLAG] <= 1'b0;
      end
      if (clr_mask[SRC_EXT1]) begin
        timer_control_reg[TC_EXT1_FLAG] <= 1'b0;
      end
      if (clr_mask[SRC_TMR0]) begin
        timer_control_reg[TC_TMR0_FLAG] <= 1'b0;
      end
      if (clr_mask[SRC_TMR1]) begin
        timer_control_reg[TC_TMR1_FLAG] <= 1'b0;
      end
      if (timer0_overflow) begin
        timer_control_reg[TC_TMR0_FLAG] <= 1'b1;
      end
      if (timer1_overflow) begin
        timer_control_reg[TC_TMR1_FLAG] <= 1'b1;
      end
      if (sample_phase) begin
        pin0_prev <= pin0_lvl;
        pin1_prev <= pin1_lvl;
        if (!timer_control_reg[TC_EXT0_EDGE]) begin
          timer_control_reg[TC_EXT0_FLAG] <= ~pin0_lvl;
        end else if (pin0_prev && !pin0_lvl) begin
          timer_control_reg[TC_EXT0_FLAG] <= 1'b1;
        end
        if (!timer_control_reg[TC_EXT1_EDGE]) begin
          timer_control_reg[TC_EXT1_FLAG] <= ~pin1_lvl;
        end else if (pin1_prev && !pin1_lvl) begin
          timer_control_reg[TC_EXT1_FLAG] <= 1'b1;
        end
      end
    end
  end

  // Serial flags; never cleared by the vector call
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_control_reg <= RESET_VAL;
    end else begin
      if (reg_wr && reg_addr == ADDR_SERIAL_CTRL) begin
        serial_control_reg <= reg_wdata;
      end
      if (receive_done) begin
        serial_control_reg[SC_RX_FLAG] <= 1'b1;
      end
      if (transmit_done) begin
        serial_control_reg[SC_TX_FLAG] <= 1'b1;
      end
    end
  end

  // Enable and priority registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_enable_reg <= RESET_VAL;
      priority_select_reg <= RESET_VAL;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_INT_ENABLE) begin
        interrupt_enable_reg <= reg_wdata;
      end
      if (reg_addr == ADDR_PRIO_SELECT) begin
        priority_select_reg <= reg_wdata;
      end
    end
  end

  // flags seen by poll are last sample-phase values
  // fixed flag bits snapshot at sample phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched <= 5'h00;
    end else if (sample_phase) begin
      latched[SRC_EXT0] <= timer_control_reg[TC_EXT0_FLAG];
      latched[SRC_TMR0] <= timer_control_reg[TC_TMR0_FLAG];
      latched[SRC_EXT1] <= timer_control_reg[TC_EXT1_FLAG];
      latched[SRC_TMR1] <= timer_control_reg[TC_TMR1_FLAG];
      latched[SRC_SER] <= serial_control_reg[SC_RX_FLAG] | serial_control_reg[SC_TX_FLAG];
    end
  end

  // isr return or enable writes hold off one instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ie_wr_seen <= 1'b0;
      hold_one <= 1'b0;
    end else begin
      if (reg_wr && (reg_addr == ADDR_INT_ENABLE || reg_addr == ADDR_PRIO_SELECT)) begin
        ie_wr_seen <= 1'b1;
      end
      if (core_last_cycle && poll_en) begin
        hold_one <= ie_wr_seen || core_return_from_isr;
        ie_wr_seen <= 1'b0;
      end
    end
  end

  assign req.pend = interrupt_enable_reg[IE_GLOBAL] ? (latched & interrupt_enable_reg[4:0])
    : 5'h00;
  assign req.high = priority_select_reg[4:0];

  // same or higher level blocks; fresh each poll
  always_comb begin
    accept = 1'b0;
    if (poll_en && state != TLVIU_CALL1 && req.valid && core_last_cycle) begin
      accept = !hold_one && !core_return_from_isr && !ie_wr_seen && !active_levels[1]
        && (req.is_high || !active_levels[0]);
    end
  end

  // two-cycle call; polled again at its end
  always_comb begin
    next_state = state;
    unique case (state)
      TLVIU_IDLE: if (accept) next_state = TLVIU_CALL1;
      TLVIU_CALL1: if (poll_en) next_state = TLVIU_CALL2;
      TLVIU_CALL2: if (poll_en) next_state = accept ? TLVIU_CALL1 : TLVIU_IDLE;
      default: next_state = TLVIU_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TLVIU_IDLE;
      call_src <= 3'h0;
      call_high <= 1'b0;
    end else begin
      state <= next_state;
      if (accept) begin
        call_src <= req.src;
        call_high <= req.is_high;
      end
    end
  end

  // push PC only, status word not saved
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      forced_vector_call <= 1'b0;
      vector_addr <= VEC_RESET;
      push_pc <= 1'b0;
      save_psw <= 1'b0;
      pop_pc <= 1'b0;
    end else begin
      forced_vector_call <= accept;
      push_pc <= accept;
      save_psw <= 1'b0;
      pop_pc <= (core_return_from_isr || core_return_sub) && core_last_cycle && poll_en;
      if (accept) begin
        vector_addr <= vec_of(req.src);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_levels <= 2'b00;
    end else if (accept) begin
      active_levels[req.is_high ? 1 : 0] <= 1'b1;
    end else if (core_return_from_isr && core_last_cycle && poll_en) begin
      if (active_levels[1]) begin
        active_levels[1] <= 1'b0;
      end else begin
        active_levels[0] <= 1'b0;
      end
    end
  end

  // Register read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_TIMER_CTRL: reg_rdata <= timer_control_reg;
        ADDR_SERIAL_CTRL: reg_rdata <= serial_control_reg;
        ADDR_INT_ENABLE: reg_rdata <= interrupt_enable_reg;
        ADDR_PRIO_SELECT: reg_rdata <= priority_select_reg;
        ADDR_STATUS: reg_rdata <= {call_high, call_src, 2'b00, active_levels};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  a_no_psw_save: assert property (@(posedge clk) disable iff (!rst_n)
    forced_vector_call |-> !save_psw) else $error("status word saved");
  a_high_block: assert property (@(posedge clk) disable iff (!rst_n)
    active_levels[1] |-> !accept) else $error("call while high level active");
  a_last_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    accept |-> core_last_cycle && poll_en) else $error("call outside last cycle");
  a_return_from_isr_block: assert property (@(posedge clk) disable iff (!rst_n)
    core_return_from_isr |-> !accept) else $error("call during return");
  a_vector_map: assert property (@(posedge clk) disable iff (!rst_n)
    accept && req.src == 3'h0 |=> vector_addr == 16'h0003) else $error("bad vector");
  // call state lasts two machine cycles
  sequence s_call;
    ##12 (state == TLVIU_CALL1 && poll_en) ##12 (state == TLVIU_CALL2 && poll_en);
  endsequence
  a_call_len: assert property (@(posedge clk) disable iff (!rst_n)
    accept |-> s_call) else $error("call length wrong");
  a_global_en: assert property (@(posedge clk) disable iff (!rst_n)
    !interrupt_enable_reg[IE_GLOBAL] |-> !accept) else $error("call while disabled");
  a_ret_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    core_return_sub && !core_return_from_isr && !accept |=> $stable(active_levels))
    else $error("plain return changed level");
  a_ser_keep: assert property (@(posedge clk) disable iff (!rst_n)
    accept && !reg_wr |=> (serial_control_reg[1:0] & $past(serial_control_reg[1:0]))
      == $past(serial_control_reg[1:0]))
    else $error("serial flag cleared by call");
endmodule

// ===== src/tlviu_pkg.sv
package tlviu_pkg;
  localparam int CLK_MHZ = 50;
  // Machine cycle length in ns, then rounded up to clk cycles
  localparam int MCYC_NS = 240;
  localparam int MCYC_CLKS = (MCYC_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] SAMPLE_PHASE_CNT = 4'(MCYC_CLKS - 1);
  // Register offsets
  localparam logic [3:0] ADDR_TIMER_CTRL = 4'h0;
  localparam logic [3:0] ADDR_SERIAL_CTRL = 4'h1;
  localparam logic [3:0] ADDR_INT_ENABLE = 4'h2;
  localparam logic [3:0] ADDR_PRIO_SELECT = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  // Timer control, serial control and enable field positions
  localparam int TC_EXT0_EDGE = 0;
  localparam int TC_EXT0_FLAG = 1;
  localparam int TC_EXT1_EDGE = 2;
  localparam int TC_EXT1_FLAG = 3;
  localparam int TC_TMR0_FLAG = 5;
  localparam int TC_TMR1_FLAG = 7;
  localparam int SC_RX_FLAG = 0;
  localparam int SC_TX_FLAG = 1;
  localparam int IE_GLOBAL = 7;
  localparam logic [7:0] RESET_VAL = 8'h00;
  // Source indices, in poll order
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_SER = 4;
  localparam int NSRC = 5;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_TMR0 = 16'h000b;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_TMR1 = 16'h001b;
  localparam logic [15:0] VEC_SER = 16'h0023;
  // Forced call length in machine cycles
  localparam logic [1:0] CALL_MCYCLES = 2'h2;
endpackage

// ===== src/tlviu_req_if.sv
`timescale 1ns/10ps
interface tlviu_req_if;
  logic [4:0] pend;
  logic [4:0] high;
  logic valid;
  logic [2:0] src;
  logic is_high;
  modport arb (input pend, input high, output valid, output src, output is_high);
  modport top (output pend, output high, input valid, input src, input is_high);
endinterface

// ===== src/tlviu_pin_sync.sv
`timescale 1ns/10ps
module tlviu_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin and settled level
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  // Three stages; a change counts only once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b1;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule

// ===== src/tlviu_poll_arb.sv
`timescale 1ns/10ps
module tlviu_poll_arb (
  // Request view
  tlviu_req_if.arb req
);
  import tlviu_pkg::*;
  logic [4:0] hi_req;
  logic [4:0] pick;
  // Fixed poll order within a level, lowest index first
  function automatic logic [2:0] first_set(input logic [4:0] v);
    first_set = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction
  always_comb begin
    hi_req = req.pend & req.high;
    pick = (hi_req != 5'h00) ? hi_req : req.pend;
    req.valid = (req.pend != 5'h00);
    req.is_high = (hi_req != 5'h00);
    req.src = first_set(pick);
  end
endmodule

// ===== verif/tlviu_core_model.sv
`timescale 1ns/10ps
module tlviu_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // From the interrupt unit
  input wire logic sample_phase,
  input wire logic forced_vector_call,
  // Bench commands
  input wire logic [2:0] instr_len,
  input wire logic [1:0] next_kind,
  // To the interrupt unit
  output logic core_last_cycle,
  output logic core_return_from_isr,
  output logic core_return_sub
);
  logic [2:0] cyc;
  logic [2:0] len;
  logic [1:0] kind;

  // sequencer steps once per machine cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc <= 3'h0;
      len <= 3'h1;
      kind <= 2'h0;
    end else if (forced_vector_call) begin
      // call runs as a two machine cycle instruction
      cyc <= 3'h0;
      len <= 3'h2;
      kind <= 2'h0;
    end else if (sample_phase) begin
      if (cyc + 3'h1 >= len) begin
        cyc <= 3'h0;
        len <= instr_len;
        kind <= next_kind;
      end else begin
        cyc <= cyc + 3'h1;
      end
    end
  end

  // levels held for whole machine cycles
  assign core_last_cycle = (cyc == len - 3'h1);
  assign core_return_from_isr = (kind == 2'h1);
  assign core_return_sub = (kind == 2'h2);
endmodule

// ===== verif/tb_tlviu_top.sv
`timescale 1ns/10ps
module tb_tlviu_top;
  import tlviu_pkg::*;
  localparam int LIMIT = 60000;
  localparam logic [15:0] VECS [5] = '{VEC_EXT0, VEC_TMR0, VEC_EXT1, VEC_TMR1, VEC_SER};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic ext_request_pin_0 = 1'b1;
  logic ext_request_pin_1 = 1'b1;
  logic timer0_overflow = 1'b0;
  logic timer1_overflow = 1'b0;
  logic receive_done = 1'b0;
  logic transmit_done = 1'b0;
  logic core_last_cycle, core_return_from_isr, core_return_sub;
  logic sample_phase, forced_vector_call, push_pc, save_psw, pop_pc;
  logic [15:0] vector_addr;
  logic [1:0] active_levels;
  logic [2:0] instr_len = 3'h1;
  logic [1:0] next_kind = 2'h0;
  logic [15:0] got_vec;
  logic [3:0] got_misc;
  logic last_ok = 1'b0;
  int calls = 0;
  int last_call = 0;
  int call_gap = 0;
  int cycles = 0;
  int err_count = 0;
  int checks_done = 0;

  always #10 clk = ~clk;

  tlviu_top tlviu_top_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_request_pin_0(ext_request_pin_0), .ext_request_pin_1(ext_request_pin_1),
    .timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow),
    .receive_done(receive_done), .transmit_done(transmit_done),
    .core_last_cycle(core_last_cycle), .core_return_from_isr(core_return_from_isr),
    .core_return_sub(core_return_sub), .core_pc_stack_ack(1'b0),
    .sample_phase(sample_phase), .forced_vector_call(forced_vector_call),
    .vector_addr(vector_addr), .push_pc(push_pc), .save_psw(save_psw), .pop_pc(pop_pc),
    .active_levels(active_levels));

  tlviu_core_model tlviu_core_model_inst (.clk(clk), .rst_n(rst_n),
    .sample_phase(sample_phase), .forced_vector_call(forced_vector_call),
    .instr_len(instr_len), .next_kind(next_kind), .core_last_cycle(core_last_cycle),
    .core_return_from_isr(core_return_from_isr), .core_return_sub(core_return_sub));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Calls are caught here, since a stimulus task may be busy when one lands
  always @(posedge clk) begin
    cycles++;
    if (forced_vector_call === 1'b1) begin
      got_vec = vector_addr;
      got_misc = {push_pc, save_psw, active_levels};
      calls++;
      call_gap = cycles - last_call;
      last_call = cycles;
      chk(16'(last_ok), 16'h1);
    end
    last_ok <= sample_phase & core_last_cycle;
    if (cycles == LIMIT) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(16'(reg_rdata), 16'(exp));
  endtask

  task automatic fire(input int s);
    @(posedge clk);
    // pin idle high, then low for two machine cycles
    // each level lasts well over twelve clocks
    if (s == SRC_EXT0)
      ext_request_pin_0 <= 1'b0;
    if (s == SRC_EXT1)
      ext_request_pin_1 <= 1'b0;
    timer0_overflow <= (s == SRC_TMR0);
    timer1_overflow <= (s == SRC_TMR1);
    transmit_done <= (s == SRC_SER);
    receive_done <= (s == SRC_SER);
    @(posedge clk);
    {timer0_overflow, timer1_overflow, transmit_done, receive_done} <= 4'h0;
    repeat (24) @(posedge clk);
    ext_request_pin_0 <= 1'b1;
    ext_request_pin_1 <= 1'b1;
  endtask

  task automatic wait_call(input logic [15:0] vec, input logic [1:0] lvl);
    for (int n = 0; n < 300 && calls == 0; n++)
      @(posedge clk);
    chk(16'(calls), 16'h1);
    calls = 0;
    chk(got_vec, vec);
    chk(16'(got_misc), {12'h0, 2'b10, lvl});
  endtask

  task automatic no_call(input int n);
    repeat (n) @(posedge clk);
    chk(16'(calls), 16'h0);
    calls = 0;
  endtask

  task automatic do_ret(input logic [1:0] k);
    int n;
    @(posedge clk);
    next_kind <= k;
    for (n = 0; n < 100 && !(core_return_from_isr | core_return_sub); n++)
      @(posedge clk);
    next_kind <= 2'h0;
    for (n = 0; n < 100 && pop_pc !== 1'b1; n++)
      @(posedge clk);
    chk(16'(pop_pc), 16'h1);
    repeat (2) @(posedge clk);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 6; a++)
      rd_chk(4'(a), 8'h00);
    rd_chk(4'hf, 8'h00);
    chk(vector_addr, VEC_RESET);
    $display("test reset done");
    wr(ADDR_INT_ENABLE, 8'h9f);
    wr(ADDR_TIMER_CTRL, 8'h05);
    for (int s = 0; s < NSRC; s++) begin
      fire(s);
      wait_call(VECS[s], 2'h1);
      rd_chk(ADDR_TIMER_CTRL, 8'h05);
      rd_chk(ADDR_SERIAL_CTRL, (s == SRC_SER) ? 8'h03 : 8'h00);
      wr(ADDR_SERIAL_CTRL, 8'h00);
      do_ret(2'h1);
      chk(16'(active_levels), 16'h0);
    end
    $display("test vectors done");
    wr(ADDR_INT_ENABLE, 8'h1f);
    wr(ADDR_TIMER_CTRL, 8'haf);
    wr(ADDR_SERIAL_CTRL, 8'h01);
    no_call(60);
    wr(ADDR_INT_ENABLE, 8'h9f);
    for (int s = 0; s < NSRC; s++) begin
      wait_call(VECS[s], 2'h1);
      if (s == SRC_SER)
        wr(ADDR_SERIAL_CTRL, 8'h00);
      do_ret(2'h1);
    end
    rd_chk(ADDR_TIMER_CTRL, 8'h05);
    $display("test order done");
    wr(ADDR_PRIO_SELECT, 8'h02);
    fire(SRC_TMR1);
    wait_call(VEC_TMR1, 2'h1);
    fire(SRC_TMR1);
    no_call(60);
    do_ret(2'h2);
    chk(16'(active_levels), 16'h1);
    no_call(60);
    fire(SRC_TMR0);
    wait_call(VEC_TMR0, 2'h3);
    fire(SRC_TMR0);
    no_call(60);
    do_ret(2'h1);
    wait_call(VEC_TMR0, 2'h3);
    do_ret(2'h1);
    chk(16'(active_levels), 16'h1);
    do_ret(2'h1);
    wait_call(VEC_TMR1, 2'h1);
    do_ret(2'h1);
    $display("test nesting done");
    wr(ADDR_PRIO_SELECT, 8'h00);
    wr(ADDR_TIMER_CTRL, 8'h00);
    fire(SRC_TMR1);
    wait_call(VEC_TMR1, 2'h1);
    ext_request_pin_0 <= 1'b0;
    repeat (48) @(posedge clk);
    ext_request_pin_0 <= 1'b1;
    repeat (48) @(posedge clk);
    do_ret(2'h1);
    no_call(80);
    // level held until the call, dropped before the handler ends
    ext_request_pin_0 <= 1'b0;
    wait_call(VEC_EXT0, 2'h1);
    ext_request_pin_0 <= 1'b1;
    repeat (36) @(posedge clk);
    do_ret(2'h1);
    no_call(80);
    $display("test level done");
    wr(ADDR_INT_ENABLE, 8'h9d);
    fire(SRC_TMR0);
    no_call(60);
    wr(ADDR_TIMER_CTRL, 8'h00);
    wr(ADDR_INT_ENABLE, 8'h9f);
    instr_len <= 3'h4;
    fire(SRC_TMR1);
    wait_call(VEC_TMR1, 2'h1);
    do_ret(2'h1);
    instr_len <= 3'h1;
    $display("test long instruction done");
    // high request latched during the call preempts at its end
    wr(ADDR_PRIO_SELECT, 8'h02);
    timer1_overflow <= 1'b1;
    @(posedge clk);
    timer1_overflow <= 1'b0;
    wait_call(VEC_TMR1, 2'h1);
    timer0_overflow <= 1'b1;
    @(posedge clk);
    timer0_overflow <= 1'b0;
    wait_call(VEC_TMR0, 2'h3);
    chk(16'(call_gap), 16'(CALL_MCYCLES * MCYC_CLKS));
    do_ret(2'h1);
    chk(16'(active_levels), 16'h1);
    do_ret(2'h1);
    chk(16'(active_levels), 16'h0);
    $display("test preempt done");
    give_verdict();
  end
endmodule
